// ### scc_pkg.sv
package scc_pkg;
	localparam int WORD_W = 32;
	localparam int SEL_W  = 5;
	localparam int RCNT_W = 5;
	localparam int CLK1_W = 12;
	localparam int FCAL_W = 10;
	localparam int INT_W  = 12;
	localparam int FHI_W  = 12;
	localparam int FLO_W  = 13;
	localparam int FDW_W  = 25;
	localparam int WAVE_W = 2;
	localparam int CP_W   = 4;

	localparam logic [SEL_W-1:0] SEL_INT   = 5'h05;
	localparam logic [SEL_W-1:0] SEL_FLO   = 5'h06;
	localparam logic [SEL_W-1:0] SEL_REF   = 5'h07;
	localparam logic [SEL_W-1:0] SEL_CAL   = 5'h08;
	localparam logic [SEL_W-1:0] SEL_SETUP = 5'h09;
	localparam logic [SEL_W-1:0] SEL_MODE  = 5'h0b;
	localparam logic [SEL_W-1:0] SEL_PUMP  = 5'h0c;
	localparam logic [SEL_W-1:0] SEL_RCLK  = 5'h0d;

	localparam int INT_LSB    = 17;
	localparam int FHI_LSB    = 5;
	localparam int FLO_LSB    = 5;
	localparam int MRST_BIT   = 25;
	localparam int CLK1_LSB   = 12;
	localparam int HALF_BIT   = 11;
	localparam int DBL_BIT    = 10;
	localparam int RCNT_LSB   = 5;
	localparam int FCAL_LSB   = 5;
	localparam int SDRST_BIT  = 11;
	localparam int TRI_BIT    = 9;
	localparam int WAVE_LSB   = 7;
	localparam int CNTCLR_BIT = 5;
	localparam int CP_LSB     = 17;
	localparam int CPTRI_BIT  = 15;
	localparam int LESYNC_BIT = 21;
	localparam int CDM_LSB    = 19;

	localparam logic [WORD_W-1:0] REG_RST        = 32'h0;
	localparam logic [WORD_W-1:0] CAL_SETUP_WORD = 32'h2a20b929;
	localparam logic [WAVE_W-1:0] WAVE_SAW_BURST = 2'h3;
endpackage

// ### scc_ref_div.sv
module scc_ref_div (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ref_in_pin,
	input  wire logic                       counter_clr,
	input  wire logic                       doubler_en,
	input  wire logic                       half_sel,
	input  wire logic [scc_pkg::RCNT_W-1:0] r_count,
	input  wire logic [scc_pkg::CLK1_W-1:0] clk1_div,
	output logic                            ref_edge,
	output logic                            cal_ref_tick,
	output logic                            step_tick
);
	import scc_pkg::*;

	logic [2:0]        sync_ff;
	logic              lvl_ff;
	logic              prev_ff;
	logic [RCNT_W-1:0] rcnt_ff;
	logic              tog_ff;
	logic [CLK1_W-1:0] step_cnt_ff;
	logic              ref_edge_ff;
	logic              cal_tick_ff;
	logic              step_tick_ff;
	logic              act;
	logic              r_wrap;
	logic              cal_tick;
	logic              s_wrap;

	// a zero limit behaves as one so a blank divider still ticks
	function automatic logic wraps(input logic [CLK1_W-1:0] cnt, input logic [CLK1_W-1:0] lim);
		return (cnt + 12'h1) >= lim;
	endfunction

	// change accepted once second and third stage agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_ff <= 3'h0;
			lvl_ff  <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync_ff <= {sync_ff[1:0], ref_in_pin};
			if (sync_ff[1] == sync_ff[2]) begin
				lvl_ff <= sync_ff[2];
			end
			prev_ff <= lvl_ff;
		end
	end

	assign act      = doubler_en ? (lvl_ff ^ prev_ff) : (prev_ff & ~lvl_ff); // [R11]
	assign r_wrap   = act && wraps({7'h0, rcnt_ff}, {7'h0, r_count}); // [R13]
	assign cal_tick = r_wrap && (!half_sel || tog_ff); // [R10]
	assign s_wrap   = cal_tick && wraps(step_cnt_ff, clk1_div); // [R9]

	always_ff @(posedge clk) begin
		if (!rst_n || counter_clr) begin
			rcnt_ff     <= 5'h0;
			tog_ff      <= 1'b0;
			step_cnt_ff <= 12'h0;
		end else begin
			if (act) begin
				rcnt_ff <= r_wrap ? 5'h0 : rcnt_ff + 5'h1; // [R13]
			end
			if (r_wrap) begin
				tog_ff <= ~tog_ff; // [R10]
			end
			if (cal_tick) begin
				step_cnt_ff <= s_wrap ? 12'h0 : step_cnt_ff + 12'h1; // [R9]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_edge_ff  <= 1'b0;
			cal_tick_ff  <= 1'b0;
			step_tick_ff <= 1'b0;
		end else begin
			ref_edge_ff  <= act;
			cal_tick_ff  <= cal_tick && !counter_clr;
			step_tick_ff <= s_wrap && !counter_clr;
		end
	end

	assign ref_edge     = ref_edge_ff;
	assign cal_ref_tick = cal_tick_ff;
	assign step_tick    = step_tick_ff;
endmodule

// ### scc_cfg_regs.sv
// Operation
// R1 - control field 00101 commits word to integer and fractional-high register
// R2 - fields 00110, 00111, 01000 select fractional-low, reference/reset, calibration divider
// R3 - fields 01011, 01100, 01101 select ramp mode, charge pump, ramp clock
// R4 - host keeps integer field, bits 28 to 17, between 75 and 4095
// R5 - fractional word joins 12 integer-register bits above 13 fractional-low bits
// R6 - host writes reserved bit positions with their fixed pattern
// R7 - reference bit 25 at one resets device and registers; zero resumes
// R8 - host keeps detector rate over calibration clock divider at most 25 kHz
// R9 - calibration clock divider also sets ramp time step duration
// R10 - reference bit 11 inserts divide-by-two toggle after reference counter
// R11 - bit 10 doubles reference using both edges; else falling edge only
// R12 - host never enables doubler above 50 MHz reference input
// R13 - five-bit reference counter divides reference; ratios 1 to 31 only
// R14 - with doubler on, host prefers pump current codes 0 through 7
// R15 - host keeps detector rate over frequency calibration divider within 100 kHz
// R16 - host loads setup register with calibration word, then normal word
// R17 - host loads second reserved register with its fixed word
// R18 - mode bit 11 clear resets modulator on each integer register write
// R19 - single triangle bit 9 valid only with waveform field 11
// R20 - waveform type taken from mode register bits 8 to 7
// R21 - mode bit 5 holds device counters in reset while set
// R22 - pump current from bits 20 to 17; bit 15 tristates pump
// R23 - ramp clock bit 21 synchronises load enable to the reference
// R24 - host sets divider mode field to 11 in ramp modes, else 00
// R25 - words shift in msb first and commit when load enable rises
module scc_cfg_regs (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ser_clk_pin,
	input  wire logic                       ser_data_pin,
	input  wire logic                       load_enable_pin,
	input  wire logic                       ref_in_pin,
	output logic [scc_pkg::INT_W-1:0]       int_value,
	output logic [scc_pkg::FDW_W-1:0]       fractional_divide_word,
	output logic                            sigma_delta_modulator_rst,
	output logic                            device_reset,
	output logic [scc_pkg::CLK1_W-1:0]      cal_clk_div,
	output logic                            half_rate_toggle_sel,
	output logic                            ref_doubler_en,
	output logic [scc_pkg::RCNT_W-1:0]      ref_count,
	output logic [scc_pkg::FCAL_W-1:0]      freq_cal_div,
	output logic                            cal_setup_sel,
	output logic [scc_pkg::WAVE_W-1:0]      waveform_type,
	output logic                            single_triangle_en,
	output logic                            counter_clear_bit,
	output logic [scc_pkg::CP_W-1:0]        pump_current,
	output logic                            pump_tristate,
	output logic                            load_sync_sel,
	output logic                            divider_mode_high,
	output logic                            divider_mode_low,
	output logic                            cal_ref_tick,
	output logic                            step_tick
);
	import scc_pkg::*;

	logic [2:0]        sync1_ff;
	logic [2:0]        sync2_ff;
	logic [2:0]        sync3_ff;
	logic [2:0]        lvl_ff;
	logic [2:0]        prev_ff;
	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] hold_ff;
	logic              load_rise_d_ff;
	logic              pend_ff;
	logic [WORD_W-1:0] int_ff;
	logic [WORD_W-1:0] flo_ff;
	logic [WORD_W-1:0] ref_ff;
	logic [WORD_W-1:0] cal_ff;
	logic              setup_ff;
	logic [WORD_W-1:0] mode_ff;
	logic [WORD_W-1:0] pump_ff;
	logic [WORD_W-1:0] rclk_ff;
	logic              mod_rst_ff;
	logic              sclk_rise;
	logic              load_rise;
	logic              ref_edge;
	logic              commit;
	logic [SEL_W-1:0]  sel;
	logic              dev_rst;
	logic              wr_int;
	logic              wr_flo;
	logic              wr_ref;
	logic              wr_cal;
	logic              wr_setup;
	logic              wr_mode;
	logic              wr_pump;
	logic              wr_rclk;

	function automatic logic hit(input logic go, input logic [SEL_W-1:0] s,
			input logic [SEL_W-1:0] code);
		return go && (s == code);
	endfunction

	// index 2 serial clock, 1 serial data, 0 load enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
			sync3_ff <= 3'h0;
			lvl_ff   <= 3'h0;
			prev_ff  <= 3'h0;
		end else begin
			sync1_ff <= {ser_clk_pin, ser_data_pin, load_enable_pin};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			for (int i = 0; i < 3; i++) begin
				if (sync2_ff[i] == sync3_ff[i]) begin
					lvl_ff[i] <= sync3_ff[i];
				end
			end
			prev_ff <= lvl_ff;
		end
	end

	assign sclk_rise = lvl_ff[2] & ~prev_ff[2];
	assign load_rise = lvl_ff[0] & ~prev_ff[0];

	// data and clock share the same filter delay, so setup is kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_ff <= REG_RST;
		end else if (sclk_rise) begin
			shift_ff <= {shift_ff[WORD_W-2:0], lvl_ff[1]}; // [R25]
		end
	end

	// word frozen at the load edge so late clocks cannot corrupt it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_ff <= REG_RST;
		end else if (load_rise) begin
			hold_ff <= shift_ff; // [R25]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			load_rise_d_ff <= 1'b0;
			pend_ff        <= 1'b0;
		end else begin
			load_rise_d_ff <= load_rise;
			if (load_rise && load_sync_sel) begin
				pend_ff <= 1'b1; // [R23]
			end else if (ref_edge) begin
				pend_ff <= 1'b0;
			end
		end
	end

	assign commit = load_sync_sel ? (pend_ff && ref_edge) : load_rise_d_ff; // [R23] [R25]
	assign sel    = hold_ff[SEL_W-1:0];

	assign wr_int   = hit(commit, sel, SEL_INT); // [R1]
	assign wr_flo   = hit(commit, sel, SEL_FLO); // [R2]
	assign wr_ref   = hit(commit, sel, SEL_REF); // [R2]
	assign wr_cal   = hit(commit, sel, SEL_CAL); // [R2]
	assign wr_setup = hit(commit, sel, SEL_SETUP);
	assign wr_mode  = hit(commit, sel, SEL_MODE); // [R3]
	assign wr_pump  = hit(commit, sel, SEL_PUMP); // [R3]
	assign wr_rclk  = hit(commit, sel, SEL_RCLK); // [R3]

	assign dev_rst = ref_ff[MRST_BIT];

	// while master reset stands only the reference word stays writable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_ff <= REG_RST;
		end else if (wr_ref) begin
			ref_ff <= hold_ff[MRST_BIT] ? (REG_RST | (32'h1 << MRST_BIT)) : hold_ff; // [R7]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			int_ff <= REG_RST; // [R7]
		end else if (wr_int) begin
			int_ff <= hold_ff; // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			flo_ff <= REG_RST;
		end else if (wr_flo) begin
			flo_ff <= hold_ff; // [R2]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			cal_ff <= REG_RST;
		end else if (wr_cal) begin
			cal_ff <= hold_ff; // [R2]
		end
	end

	// only whether the calibration setup word is loaded matters here
	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			setup_ff <= 1'b0;
		end else if (wr_setup) begin
			setup_ff <= (hold_ff == CAL_SETUP_WORD);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			mode_ff <= REG_RST;
		end else if (wr_mode) begin
			mode_ff <= hold_ff; // [R3]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			pump_ff <= REG_RST;
		end else if (wr_pump) begin
			pump_ff <= hold_ff; // [R3]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || dev_rst) begin
			rclk_ff <= REG_RST;
		end else if (wr_rclk) begin
			rclk_ff <= hold_ff; // [R3]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mod_rst_ff <= 1'b0;
		end else begin
			mod_rst_ff <= wr_int && !dev_rst && !mode_ff[SDRST_BIT]; // [R18]
		end
	end

	assign int_value              = int_ff[INT_LSB +: INT_W];
	assign fractional_divide_word = {int_ff[FHI_LSB +: FHI_W], flo_ff[FLO_LSB +: FLO_W]}; // [R5]
	assign sigma_delta_modulator_rst = mod_rst_ff;
	assign device_reset           = dev_rst; // [R7]
	assign cal_clk_div            = ref_ff[CLK1_LSB +: CLK1_W];
	assign half_rate_toggle_sel   = ref_ff[HALF_BIT];
	assign ref_doubler_en         = ref_ff[DBL_BIT];
	assign ref_count              = ref_ff[RCNT_LSB +: RCNT_W];
	assign freq_cal_div           = cal_ff[FCAL_LSB +: FCAL_W];
	assign cal_setup_sel          = setup_ff;
	assign waveform_type          = mode_ff[WAVE_LSB +: WAVE_W]; // [R20]
	// ignored outside single sawtooth burst rather than trusting the host
	assign single_triangle_en     = mode_ff[TRI_BIT] && (waveform_type == WAVE_SAW_BURST); // [R19]
	assign counter_clear_bit      = mode_ff[CNTCLR_BIT]; // [R21]
	assign pump_current           = pump_ff[CP_LSB +: CP_W]; // [R22]
	assign pump_tristate          = pump_ff[CPTRI_BIT]; // [R22]
	assign load_sync_sel          = rclk_ff[LESYNC_BIT]; // [R23]
	assign divider_mode_high      = rclk_ff[CDM_LSB + 1];
	assign divider_mode_low       = rclk_ff[CDM_LSB];

	scc_ref_div u_ref_div (
		.clk          (clk),
		.rst_n        (rst_n),
		.ref_in_pin   (ref_in_pin),
		.counter_clr  (counter_clear_bit || dev_rst), // [R21]
		.doubler_en   (ref_doubler_en), // [R11]
		.half_sel     (half_rate_toggle_sel), // [R10]
		.r_count      (ref_count), // [R13]
		.clk1_div     (cal_clk_div), // [R9]
		.ref_edge     (ref_edge),
		.cal_ref_tick (cal_ref_tick),
		.step_tick    (step_tick)
	);

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence int_write_s;
		wr_int && !dev_rst && !mode_ff[SDRST_BIT];
	endsequence

	sequence mod_pulse_s;
		sigma_delta_modulator_rst ##1 !sigma_delta_modulator_rst;
	endsequence

	sequence load_held_s;
		load_rise && load_sync_sel && !ref_edge;
	endsequence

	int_commit_a: assert property ( // [R1]
		(wr_int && !dev_rst) |=> int_ff == $past(hold_ff))
		else $error("integer word not committed");

	low_route_a: assert property ( // [R2]
		(wr_flo && !dev_rst) |=> fractional_divide_word[FLO_W-1:0] == $past(hold_ff[17:5]))
		else $error("fractional low word not committed");

	ref_route_a: assert property ( // [R2]
		(wr_ref && !hold_ff[MRST_BIT]) |=> ref_count == $past(hold_ff[9:5]))
		else $error("reference word not committed");

	mode_route_a: assert property ( // [R3]
		(wr_mode && !dev_rst) |=> waveform_type == $past(hold_ff[8:7]))
		else $error("waveform field not committed");

	high_join_a: assert property ( // [R5]
		(wr_int && !dev_rst) |=> fractional_divide_word[FDW_W-1:FLO_W] == $past(hold_ff[16:5]))
		else $error("fractional upper bits misplaced");

	master_reset_a: assert property ( // [R7]
		dev_rst |=> (int_ff == REG_RST) && (pump_current == 4'h0) && !counter_clear_bit)
		else $error("master reset left registers set");

	mod_reset_a: assert property ( // [R18]
		int_write_s |=> mod_pulse_s)
		else $error("modulator reset pulse missing");

	mod_skip_a: assert property ( // [R18]
		(wr_int && mode_ff[SDRST_BIT]) |=> !sigma_delta_modulator_rst)
		else $error("modulator reset despite skip bit");

	pump_route_a: assert property ( // [R22]
		(wr_pump && !dev_rst) |=> pump_current == $past(hold_ff[20:17])
			&& pump_tristate == $past(hold_ff[15]))
		else $error("pump fields not committed");

	load_sync_a: assert property ( // [R23]
		load_held_s |=> pend_ff && (commit == ref_edge))
		else $error("synchronised load committed early");

	counter_hold_a: assert property ( // [R21]
		counter_clear_bit [*2] |-> !cal_ref_tick && !step_tick)
		else $error("counters ran while held");

	triangle_gate_a: assert property ( // [R19]
		$rose(single_triangle_en) |-> waveform_type == 2'h3 && mode_ff[9])
		else $error("single triangle outside burst mode");
endmodule

// ### scc_host_model.sv
module scc_host_model (
	input  wire logic clk,
	output logic      ser_clk_pin,
	output logic      ser_data_pin,
	output logic      load_enable_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		ser_clk_pin = 1'h0;
		ser_data_pin = 1'h0;
		load_enable_pin = 1'h0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	// every level held at least 4 clk, the pin filters drop single-clk pulses
	task automatic send_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			ser_data_pin = w[i];
			wait_clk(4);
			ser_clk_pin = 1'h1;
			wait_clk(4);
			ser_clk_pin = 1'h0;
		end
		wait_clk(4);
		ser_data_pin = ~w[0]; // line driven to the inverse of the last bit: no stale bit shown
		load_enable_pin = 1'h1;
		wait_clk(6);
		load_enable_pin = 1'h0;
		wait_clk(4);
	endtask
endmodule

// ### scc_cfg_regs_bench.sv
module scc_cfg_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import scc_pkg::*;

	typedef struct packed {
		logic [31:0] w;
		logic [2:0]  k;
		logic [31:0] e;
	} scc_row_t;

	logic                clk, rst_n, ref_in_pin, counting;
	logic                ser_clk_pin, ser_data_pin, load_enable_pin;
	logic [INT_W-1:0]    int_value;
	logic [FDW_W-1:0]    fractional_divide_word;
	logic [CLK1_W-1:0]   cal_clk_div;
	logic [RCNT_W-1:0]   ref_count;
	logic [FCAL_W-1:0]   freq_cal_div;
	logic [WAVE_W-1:0]   waveform_type;
	logic [CP_W-1:0]     pump_current;
	logic                sigma_delta_modulator_rst, device_reset, half_rate_toggle_sel;
	logic                ref_doubler_en, cal_setup_sel, single_triangle_en, counter_clear_bit;
	logic                pump_tristate, load_sync_sel, divider_mode_high, divider_mode_low;
	logic                cal_ref_tick, step_tick;
	int                  miscompares = 0, n_compared = 0, cycles = 0;
	int                  mod_pulses = 0, cal_seen = 0, step_seen = 0;
	scc_row_t            rows[17];

	scc_cfg_regs DUT (.clk, .rst_n, .ser_clk_pin, .ser_data_pin, .load_enable_pin, .ref_in_pin,
		.int_value, .fractional_divide_word, .sigma_delta_modulator_rst, .device_reset,
		.cal_clk_div, .half_rate_toggle_sel, .ref_doubler_en, .ref_count, .freq_cal_div,
		.cal_setup_sel, .waveform_type, .single_triangle_en, .counter_clear_bit,
		.pump_current, .pump_tristate, .load_sync_sel, .divider_mode_high, .divider_mode_low,
		.cal_ref_tick, .step_tick);

	scc_host_model host (.clk, .ser_clk_pin, .ser_data_pin, .load_enable_pin);

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// slow reference, far under the doubler input limit
	initial begin
		ref_in_pin = 1'h0;
		forever begin
			repeat (8) @(posedge clk);
			#5 ref_in_pin = ~ref_in_pin;
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (sigma_delta_modulator_rst === 1'h1) mod_pulses <= mod_pulses + 1;
		if (counting && cal_ref_tick === 1'h1) cal_seen <= cal_seen + 1;
		if (counting && step_tick === 1'h1) step_seen <= step_seen + 1;
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic logic [31:0] obs(input logic [2:0] k);
		case (k)
			3'h0: obs = {8'h0, int_value, fractional_divide_word[24:13]};
			3'h1: obs = {7'h0, fractional_divide_word};
			3'h2: obs = {12'h0, device_reset, cal_clk_div, half_rate_toggle_sel,
				ref_doubler_en, ref_count};
			3'h3: obs = {22'h0, freq_cal_div};
			3'h4: obs = {31'h0, cal_setup_sel};
			3'h5: obs = {28'h0, waveform_type, single_triangle_en, counter_clear_bit};
			3'h6: obs = {27'h0, pump_current, pump_tristate};
			default: obs = {29'h0, load_sync_sel, divider_mode_high, divider_mode_low};
		endcase
	endfunction

	function automatic logic [31:0] refw(input logic mr, input logic [11:0] cd,
		input logic hf, input logic db, input logic [4:0] cnt);
		refw = {6'h0, mr, 1'h0, cd, hf, db, cnt, SEL_REF};
	endfunction

	function automatic logic [31:0] modew(input logic skip, input logic tri_on,
		input logic [1:0] wave, input logic clr);
		modew = {20'h0, skip, 1'h0, tri_on, wave, 1'h0, clr, SEL_MODE};
	endfunction

	// load sync may add up to one reference period before the commit
	task automatic wr(input logic [31:0] w);
		host.send_word(w);
		repeat (40) @(posedge clk);
		#5;
	endtask

	task automatic count_ticks(input int win);
		cal_seen = 0;
		step_seen = 0;
		counting = 1'h1;
		repeat (win) @(posedge clk);
		#5 counting = 1'h0;
	endtask

	// one settle window first, the divider phase after a write is not defined
	task automatic ticks(input logic db, input logic hf, input logic [4:0] cnt,
		input logic [11:0] cd, input int win, input int ec, input int es);
		wr(refw(1'h0, cd, hf, db, cnt));
		repeat (win) @(posedge clk);
		#5 count_ticks(win);
		check(32'(cal_seen), 32'(ec), "cal ticks");
		check(32'(step_seen), 32'(es), "step ticks");
	endtask

	initial begin
		rst_n = 1'h0;
		counting = 1'h0;
		repeat (5) @(posedge clk);
		#5 rst_n = 1'h1;
		for (int k = 0; k < 8; k++) check(obs(3'(k)), 32'h0, "reset value");
		rows = '{
			'{{3'h0, 12'hfff, 12'hfff, SEL_INT}, 3'h0, {8'h0, 12'hfff, 12'hfff}},
			'{{3'h0, 12'h04b, 12'h5a5, SEL_INT}, 3'h0, {8'h0, 12'h04b, 12'h5a5}},
			'{{14'h0, 13'h1abc, SEL_FLO}, 3'h1, {7'h0, 12'h5a5, 13'h1abc}},
			'{refw(1'h0, 12'habc, 1'h1, 1'h0, 5'h1f), 3'h2, {13'h0, 12'habc, 2'h2, 5'h1f}},
			'{refw(1'h0, 12'h001, 1'h0, 1'h1, 5'h01), 3'h2, {13'h0, 12'h001, 2'h1, 5'h01}},
			'{{17'h0, 10'h3ff, SEL_CAL}, 3'h3, {22'h0, 10'h3ff}},
			'{32'h1d32a64a, 3'h3, {22'h0, 10'h3ff}},
			'{{27'h7ffffff, 5'h1f}, 3'h3, {22'h0, 10'h3ff}},
			'{32'h2a20b929, 3'h4, 32'h1},
			'{32'h2800b929, 3'h4, 32'h0},
			'{modew(1'h0, 1'h1, 2'h3, 1'h0), 3'h5, {28'h0, 2'h3, 2'h2}},
			'{modew(1'h0, 1'h1, 2'h2, 1'h0), 3'h5, {28'h0, 2'h2, 2'h0}},
			'{modew(1'h0, 1'h1, 2'h1, 1'h1), 3'h5, {28'h0, 2'h1, 2'h1}},
			'{modew(1'h0, 1'h1, 2'h0, 1'h0), 3'h5, 32'h0},
			'{{11'h0, 4'ha, 2'h1, 10'h0, SEL_PUMP}, 3'h6, {27'h0, 4'ha, 1'h1}},
			'{{11'h0, 4'h7, 2'h0, 10'h0, SEL_PUMP}, 3'h6, {27'h0, 4'h7, 1'h0}},
			'{{10'h0, 1'h1, 2'h3, 14'h0, SEL_RCLK}, 3'h7, {29'h0, 3'h7}}
		};
		foreach (rows[i]) begin
			wr(rows[i].w);
			check(obs(rows[i].k), rows[i].e, "register row");
		end
		// sync still on: this commit waits for a reference edge
		wr({10'h0, 1'h0, 2'h1, 14'h0, SEL_RCLK});
		check(obs(3'h7), {29'h0, 3'h1}, "sync off");
		mod_pulses = 0;
		wr({3'h0, 12'h078, 12'h200, SEL_INT});
		check(32'(mod_pulses), 32'h1, "modulator reset");
		wr(modew(1'h1, 1'h0, 2'h0, 1'h0));
		mod_pulses = 0;
		wr({3'h0, 12'h079, 12'h200, SEL_INT});
		check(32'(mod_pulses), 32'h0, "modulator kept");
		wr(modew(1'h0, 1'h0, 2'h0, 1'h0));
		ticks(1'h0, 1'h0, 5'h01, 12'h001, 640, 40, 40);
		ticks(1'h1, 1'h0, 5'h01, 12'h001, 640, 80, 80);
		ticks(1'h0, 1'h0, 5'h04, 12'h005, 640, 10, 2);
		ticks(1'h0, 1'h1, 5'h02, 12'h002, 640, 10, 5);
		ticks(1'h0, 1'h0, 5'h1f, 12'h001, 992, 2, 2);
		wr(modew(1'h0, 1'h0, 2'h0, 1'h1));
		count_ticks(200);
		check(32'(cal_seen), 32'h0, "ticks while held");
		wr(modew(1'h0, 1'h0, 2'h0, 1'h0));
		wr({11'h0, 4'h5, 2'h1, 10'h0, SEL_PUMP});
		wr(refw(1'h1, 12'h0, 1'h0, 1'h0, 5'h0));
		check(obs(3'h2), 32'h00080000, "master reset set");
		check(obs(3'h6), 32'h0, "pump cleared");
		wr({11'h0, 4'h5, 2'h1, 10'h0, SEL_PUMP});
		check(obs(3'h6), 32'h0, "write during reset");
		wr(refw(1'h0, 12'h0, 1'h0, 1'h0, 5'h0));
		check(obs(3'h2), 32'h0, "master reset off");
		wr({11'h0, 4'h5, 2'h1, 10'h0, SEL_PUMP});
		check(obs(3'h6), {27'h0, 4'h5, 1'h1}, "write after reset");
		// reset pulled again mid-run: every register back to zero, link usable after
		rst_n = 1'h0;
		repeat (5) @(posedge clk);
		#5 rst_n = 1'h1;
		for (int k = 0; k < 8; k++) check(obs(3'(k)), 32'h0, "mid-run reset");
		wr({3'h0, 12'h4d2, 12'h123, SEL_INT});
		check(obs(3'h0), {8'h0, 12'h4d2, 12'h123}, "write after mid-run reset");
		finish_test();
	end
endmodule
